//--- hdl/capture_pkg.sv
// Constants shared by the input capture channel and its capture store.
package capture_pkg;

    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam int          FIFO_DEPTH       = 4;
    localparam int          PTR_W            = 2;

    localparam logic [7:0]  CONTROL_OFFSET   = 8'h00;
    localparam logic [7:0]  BUFFER_OFFSET    = 8'h04;

    localparam int          ENABLE_BIT       = 15;
    localparam int          IDLE_STOP_BIT    = 13;
    localparam int          FIRST_EDGE_BIT   = 9;
    localparam int          WIDE_BIT         = 8;
    localparam int          TIMER_SEL_BIT    = 7;
    localparam int          DECIM_HI         = 6;
    localparam int          DECIM_LO         = 5;
    localparam int          OVERFLOW_BIT     = 4;
    localparam int          NOT_EMPTY_BIT    = 3;
    localparam int          MODE_HI          = 2;
    localparam int          MODE_LO          = 0;

    localparam logic [31:0] CONTROL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CONTROL_WMASK    = 32'h0000_A3E7;

    localparam logic [2:0]  MODE_OFF         = 3'h0;
    localparam logic [2:0]  MODE_EVERY_EDGE  = 3'h1;
    localparam logic [2:0]  MODE_FALLING     = 3'h2;
    localparam logic [2:0]  MODE_RISING      = 3'h3;
    localparam logic [2:0]  MODE_RISING_4TH  = 3'h4;
    localparam logic [2:0]  MODE_RISING_16TH = 3'h5;
    localparam logic [2:0]  MODE_EDGE_PAIR   = 3'h6;

    localparam logic [3:0]  PRESCALE_4_LAST  = 4'h3;
    localparam logic [3:0]  PRESCALE_16_LAST = 4'hF;

    typedef enum logic {PAIR_ARMED, PAIR_STREAMING} pair_state_t;

endpackage : capture_pkg

//--- hdl/capture_fifo_if.sv
// Signals between the capture channel control and its capture store.
`timescale 1ns/1ps
interface capture_fifo_if;
    logic        flush;
    logic        push;
    logic [31:0] push_data;
    logic        pop;
    logic [31:0] head;
    logic        not_empty;
    logic        full;

    modport writer (output flush, push, push_data, pop, input head, not_empty, full);
    modport store  (input flush, push, push_data, pop, output head, not_empty, full);
endinterface : capture_fifo_if

//--- hdl/capture_fifo.sv
// Small first-in first-out store for captured timer values.
`timescale 1ns/1ps
module capture_fifo
    import capture_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    rst,
    capture_fifo_if.store port
);

    logic [31:0]  mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             do_push;
    logic             do_pop;

    assign do_push        = port.push && !port.full;
    assign do_pop         = port.pop && port.not_empty;
    assign port.head      = mem[rd_ptr_reg];
    assign port.not_empty = (count_reg != '0);
    assign port.full      = (count_reg == (PTR_W+1)'(FIFO_DEPTH));

    // The array holds data only, so it needs no reset.
    always_ff @(posedge clock)
    begin
        if (do_push)
        begin
            mem[wr_ptr_reg] <= port.push_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst || port.flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : capture_fifo

//--- hdl/input_capture_control.sv
// Input capture channel: control register, edge capture, buffer and decimated interrupt.
`timescale 1ns/1ps
module input_capture_control
    import capture_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        capture_pin,
    input  wire logic        idle_mode,
    input  wire logic [15:0] second_timer,
    input  wire logic [15:0] third_timer,
    input  wire logic [31:0] wide_timer,
    output logic             capture_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [31:0]  control_reg;
    logic [31:0]  rdata_reg;
    logic         pin_meta_reg;
    logic         pin_sync_reg;
    logic         pin_prev_reg;
    logic         overflow_reg;
    logic [3:0]   prescale_reg;
    logic [1:0]   decim_count_reg;
    logic         irq_reg;
    pair_state_t  pair_state_reg;
    pair_state_t  pair_state_next;

    logic         enable;
    logic         stop_in_idle;
    logic         first_edge_select;
    logic         wide_capture_select;
    logic         timer_source_select;
    logic [1:0]   interrupt_decimation;
    logic [2:0]   capture_mode_field;
    logic         running;
    logic         rise;
    logic         fall;
    logic         capture_hit;
    logic         accepted;
    logic [31:0]  capture_value;
    logic         control_sel;
    logic         buffer_sel;
    logic [31:0]  control_view;

    capture_fifo_if fifo_bus ();

    capture_fifo u_fifo
    (
        .clock (clock),
        .rst   (rst),
        .port  (fifo_bus.store)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control fields.

    assign enable               = control_reg[ENABLE_BIT];
    assign stop_in_idle         = control_reg[IDLE_STOP_BIT];
    assign first_edge_select    = control_reg[FIRST_EDGE_BIT];
    assign wide_capture_select  = control_reg[WIDE_BIT];
    assign timer_source_select  = control_reg[TIMER_SEL_BIT];
    assign interrupt_decimation = control_reg[DECIM_HI:DECIM_LO];
    assign capture_mode_field   = control_reg[MODE_HI:MODE_LO];

    assign control_sel = (reg_addr == CONTROL_OFFSET);
    assign buffer_sel  = (reg_addr == BUFFER_OFFSET);

    // The channel only advances while enabled and not parked by idle.
    assign running = enable && !(idle_mode && stop_in_idle);

    ////////////////////////////////////////////////////////////////////////////////
    // Control register.

    // Configuration stays writable at all times; software is expected to
    // change it only while the channel is disabled.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            control_reg <= CONTROL_RESET;
        end
        else if (reg_write && control_sel)
        begin
            control_reg <= reg_wdata & CONTROL_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detection.

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= capture_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign rise = pin_sync_reg && !pin_prev_reg;
    assign fall = !pin_sync_reg && pin_prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Capture decision per mode.

    always_comb
    begin
        capture_hit = 1'b0;
        case (capture_mode_field)
            MODE_EVERY_EDGE:  capture_hit = rise || fall;
            MODE_FALLING:     capture_hit = fall;
            MODE_RISING:      capture_hit = rise;
            MODE_RISING_4TH:  capture_hit = rise && (prescale_reg == PRESCALE_4_LAST);
            MODE_RISING_16TH: capture_hit = rise && (prescale_reg == PRESCALE_16_LAST);
            MODE_EDGE_PAIR:
            begin
                if (pair_state_reg == PAIR_ARMED)
                begin
                    capture_hit = first_edge_select ? rise : fall;
                end
                else
                begin
                    capture_hit = rise || fall;
                end
            end
            default:          capture_hit = 1'b0;
        endcase
        capture_hit = capture_hit && running;
    end

    // Rising-edge prescaler for the every-4th and every-16th modes.
    always_ff @(posedge clock)
    begin
        if (rst || !enable)
        begin
            prescale_reg <= '0;
        end
        else if (running && rise)
        begin
            if (capture_mode_field == MODE_RISING_4TH && prescale_reg == PRESCALE_4_LAST)
            begin
                prescale_reg <= '0;
            end
            else
            begin
                prescale_reg <= prescale_reg + 1'b1;
            end
        end
    end

    // The pair mode waits for its chosen first edge, then takes both edges.
    always_comb
    begin
        pair_state_next = pair_state_reg;
        case (pair_state_reg)
            PAIR_ARMED:
            begin
                if (capture_mode_field == MODE_EDGE_PAIR && capture_hit)
                begin
                    pair_state_next = PAIR_STREAMING;
                end
            end
            PAIR_STREAMING:
            begin
                if (capture_mode_field != MODE_EDGE_PAIR)
                begin
                    pair_state_next = PAIR_ARMED;
                end
            end
            default:
            begin
                pair_state_next = PAIR_ARMED;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst || !enable)
        begin
            pair_state_reg <= PAIR_ARMED;
        end
        else
        begin
            pair_state_reg <= pair_state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer selection and buffering.

    always_comb
    begin
        if (wide_capture_select)
        begin
            capture_value = wide_timer;
        end
        else if (timer_source_select)
        begin
            capture_value = {16'h0000, second_timer};
        end
        else
        begin
            capture_value = {16'h0000, third_timer};
        end
    end

    assign accepted           = capture_hit && !fifo_bus.full;
    assign fifo_bus.flush     = !enable;
    assign fifo_bus.push      = accepted;
    assign fifo_bus.push_data = capture_value;
    assign fifo_bus.pop       = reg_read && buffer_sel && fifo_bus.not_empty;

    // A capture that finds the buffer full is dropped, never overwrites.
    always_ff @(posedge clock)
    begin
        if (rst || !enable)
        begin
            overflow_reg <= 1'b0;
        end
        else if (capture_hit && fifo_bus.full)
        begin
            overflow_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt decimation.

    always_ff @(posedge clock)
    begin
        if (rst || !enable)
        begin
            decim_count_reg <= '0;
            irq_reg         <= 1'b0;
        end
        else if (accepted)
        begin
            if (decim_count_reg == interrupt_decimation)
            begin
                decim_count_reg <= '0;
                irq_reg         <= 1'b1;
            end
            else
            begin
                decim_count_reg <= decim_count_reg + 1'b1;
                irq_reg         <= 1'b0;
            end
        end
        else
        begin
            irq_reg <= 1'b0;
        end
    end

    assign capture_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.

    always_comb
    begin
        control_view                = control_reg & CONTROL_WMASK;
        control_view[OVERFLOW_BIT]  = overflow_reg;
        control_view[NOT_EMPTY_BIT] = fifo_bus.not_empty;
    end

    // Read data stand for one cycle only; unmapped reads return zero.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (reg_read && control_sel)
        begin
            rdata_reg <= control_view;
        end
        else if (reg_read && buffer_sel)
        begin
            rdata_reg <= fifo_bus.not_empty ? fifo_bus.head : 32'h0000_0000;
        end
        else
        begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : input_capture_control

//--- testbench/capture_props.sv
// Concurrent checks on the ports of the input capture channel.
`timescale 1ns/1ps
module capture_props
    import capture_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        capture_pin,
    input wire logic        idle_mode,
    input wire logic [15:0] second_timer,
    input wire logic [15:0] third_timer,
    input wire logic [31:0] wide_timer,
    input wire logic        capture_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence ctl_read;
        reg_read && reg_addr == CONTROL_OFFSET;
    endsequence
    sequence ctl_write;
        reg_write && reg_addr == CONTROL_OFFSET;
    endsequence
    // The pin path is three flops deep, so an interrupt trails its pin edge by a few cycles.
    sequence pin_moved;
        ($past(capture_pin, 3) != $past(capture_pin, 4)) || ($past(capture_pin, 4) != $past(capture_pin, 5))
            || ($past(capture_pin, 5) != $past(capture_pin, 6));
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_rdata_quiet: assert property (!reg_read |=> reg_rdata == 32'h0) else $error("read data not zero");
    a_reserved_zero: assert property (ctl_read |=> (reg_rdata & 32'hFFFF_5C00) == 32'h0)
        else $error("reserved control bits not zero");
    a_write_readback: assert property (ctl_write ##1 ctl_read |=>
        ((reg_rdata ^ $past(reg_wdata, 2)) & CONTROL_WMASK) == 32'h0) else $error("control readback wrong");
    a_off_status: assert property (ctl_read ##1 !reg_rdata[15] |-> reg_rdata[4:3] == 2'b00)
        else $error("status set while disabled");
    a_irq_single: assert property (capture_irq |=> !capture_irq) else $error("interrupt longer than one cycle");
    a_irq_cause: assert property (capture_irq |-> pin_moved) else $error("interrupt without pin edge");
    // A capture launched in the very cycle of the disabling write may still pulse once, hence the delay.
    a_disable_quiet: assert property (reg_write && reg_addr == CONTROL_OFFSET && !reg_wdata[15]
        |-> ##3 !capture_irq [*8]) else $error("interrupt after disable");
    a_unmapped_zero: assert property (reg_read && reg_addr != CONTROL_OFFSET && reg_addr != BUFFER_OFFSET
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
endmodule : capture_props

bind input_capture_control capture_props u_props (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .capture_pin(capture_pin), .idle_mode(idle_mode), .second_timer(second_timer),
    .third_timer(third_timer), .wide_timer(wide_timer), .capture_irq(capture_irq));

//--- testbench/capture_source.sv
// Model of the capture pin driver and the three timers feeding the channel.
`timescale 1ns/1ps
module capture_source
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        pin_req,
    output logic             capture_pin,
    output logic      [15:0] second_timer,
    output logic      [15:0] third_timer,
    output logic      [31:0] wide_timer
);
    // Distinct start values keep the three sources apart, so a wrong selection shows in the captured value.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            second_timer <= 16'h1000;
            third_timer  <= 16'h2000;
            wide_timer   <= 32'h3000_0000;
        end
        else if (run)
        begin
            second_timer <= second_timer + 16'h0001;
            third_timer  <= third_timer + 16'h0003;
            wide_timer   <= wide_timer + 32'h0001_0001;
        end
    end
    always_ff @(posedge clock)
    begin
        capture_pin <= rst ? 1'b0 : pin_req;
    end
endmodule : capture_source

//--- testbench/input_capture_control_tb.sv
// Self-checking testbench for the input capture channel.
`timescale 1ns/1ps
module input_capture_control_tb;
    import capture_pkg::*;
    logic        clock, rst, reg_write, reg_read, idle_mode, run, pin_req, capture_pin, capture_irq;
    logic [7:0]  reg_addr;
    logic [15:0] second_timer, third_timer;
    logic [31:0] reg_wdata, reg_rdata, wide_timer, got, exp;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          irq_cnt = 0;
    int          irq_base = 0;
    int          cycles = 0;
    int          mode_tab[9] = '{0, 1, 2, 3, 4, 5, 6, 6, 7};
    int          edge_tab[9] = '{0, 0, 0, 0, 0, 0, 1, 0, 0};
    int          puls_tab[9] = '{1, 1, 1, 1, 4, 16, 1, 1, 1};
    int          capt_tab[9] = '{0, 2, 1, 1, 1, 1, 2, 1, 0};
    ////////////////////////////////////////////////////////////////////////////////
    input_capture_control dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .capture_pin(capture_pin),
        .idle_mode(idle_mode), .second_timer(second_timer), .third_timer(third_timer),
        .wide_timer(wide_timer), .capture_irq(capture_irq));
    capture_source source (.clock(clock), .rst(rst), .run(run), .pin_req(pin_req), .capture_pin(capture_pin),
        .second_timer(second_timer), .third_timer(third_timer), .wide_timer(wide_timer));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Cuts a hang short; the whole run needs well under this many cycles.
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        irq_cnt <= irq_cnt + ((capture_irq === 1'b1) ? 1 : 0);
        if (cycles == 5000)
        begin
            num_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Tasks are entered just after a clock edge, so strobes may follow each other with no gap.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected word at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk_word
    task automatic chk_count(input int e, input int g);
        cmp_count++;
        if (g != e)
        begin
            num_errors++;
            $display("unexpected count at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk_count
    task automatic pulse(input int n);
        repeat (n)
        begin
            pin_req <= 1'b1;
            repeat (3) @(posedge clock);
            pin_req <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask : pulse
    // Disabling leaves a quiet spell before the next access, long enough that the channel is still off
    // while the checker watches for stray interrupts after the disable.
    // The interrupt tally is only read here, never written, so the counting process stays its sole driver.
    task automatic cfg(input logic [31:0] v);
        wr(CONTROL_OFFSET, 32'h0);
        repeat (8) @(posedge clock);
        wr(CONTROL_OFFSET, v);
        irq_base = irq_cnt;
    endtask : cfg
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_write, reg_read, idle_mode, run, pin_req} = 5'b0;
        {reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        run <= 1'b1;
        @(posedge clock);
        rd(CONTROL_OFFSET, got);
        chk_word(32'h0, got);
        wr(CONTROL_OFFSET, 32'hFFFF_FFFF);
        rd(CONTROL_OFFSET, got);
        chk_word(32'h0000_A3E7, got);
        wr(8'h08, 32'hFFFF_FFFF);
        rd(8'h08, got);
        chk_word(32'h0, got);
        for (int i = 0; i < 9; i++)
        begin
            exp = 32'h8000 | (edge_tab[i] << 9) | mode_tab[i];
            cfg(exp);
            pulse(puls_tab[i]);
            chk_count(capt_tab[i], irq_cnt - irq_base);
            rd(CONTROL_OFFSET, got);
            chk_word(exp | ((capt_tab[i] > 0) ? 32'h8 : 32'h0), got);
        end
        for (int d = 0; d < 4; d++)
        begin
            cfg(32'h8000 | (d << 5) | MODE_EVERY_EDGE);
            repeat (6)
            begin
                pulse(1);
                rd(BUFFER_OFFSET, got);
                rd(BUFFER_OFFSET, got);
            end
            chk_count(12 / (d + 1), irq_cnt - irq_base);
        end
        run <= 1'b0;
        for (int j = 0; j < 4; j++)
        begin
            cfg(32'h8000 | (j < 2 ? 32'h100 : 32'h0) | (j % 2 == 1 ? 32'h80 : 32'h0) | MODE_RISING);
            exp = (j < 2) ? wide_timer : {16'h0, (j == 3) ? second_timer : third_timer};
            pulse(1);
            rd(BUFFER_OFFSET, got);
            chk_word(exp, got);
            rd(BUFFER_OFFSET, got);
            chk_word(32'h0, got);
        end
        run <= 1'b1;
        cfg(32'h8000 | MODE_RISING);
        pulse(5);
        rd(CONTROL_OFFSET, got);
        chk_word(32'h0000_801B, got);
        repeat (4) rd(BUFFER_OFFSET, got);
        rd(CONTROL_OFFSET, got);
        chk_word(32'h0000_8013, got);
        cfg(32'h0);
        repeat (2) @(posedge clock);
        rd(CONTROL_OFFSET, got);
        chk_word(32'h0, got);
        idle_mode <= 1'b1;
        cfg(32'h8000 | 32'h2000 | MODE_RISING);
        pulse(1);
        chk_count(0, irq_cnt - irq_base);
        cfg(32'h8000 | MODE_RISING);
        pulse(1);
        chk_count(1, irq_cnt - irq_base);
        end_sim();
    end
endmodule : input_capture_control_tb
